// *** rtl/mch_defines.vh ***
// Purpose: Constants of the machine check handler
// Assumes: 32-bit registers, bit 0 is the most significant bit in the
//          numbering used by software; Verilog index = 31 - bit number
// Notes:   Offsets are byte addresses on the plain register port
`ifndef MCH_DEFINES_VH
`define MCH_DEFINES_VH

// ==========================================================
// Register offsets
`define MCH_OFS_CONFIG 8'h00
`define MCH_OFS_SAVED_STATE 8'h04
`define MCH_OFS_RETURN_ADDR 8'h08
`define MCH_OFS_MACHINE_STATE 8'h0c

// ==========================================================
// Reset values
`define MCH_RST_CONFIG 32'h00000000
`define MCH_RST_SAVED_STATE 32'h00000000
`define MCH_RST_RETURN_ADDR 32'h00000000
`define MCH_RST_MACHINE_STATE 32'h00000000

// ==========================================================
// Configuration register fields
`define MCH_CFG_CHECK_PIN_ENABLE 31
`define MCH_CFG_BUS_PARITY_GENERATE 30
`define MCH_CFG_ADDR_PARITY_CHECK 29
`define MCH_CFG_DATA_PARITY_CHECK 28
`define MCH_CFG_NOT_HARD_RESET 16

// ==========================================================
// Machine state register fields
`define MCH_MS_INT_LITTLE_ENDIAN 16
`define MCH_MS_CHECK_ENABLE 12
`define MCH_MS_EXCEPTION_PREFIX 6
`define MCH_MS_LITTLE_ENDIAN 0

// ==========================================================
// Saved state source flags and copied field
`define MCH_SS_L2_PARITY 20
`define MCH_SS_CHECK_PIN 19
`define MCH_SS_TRANSFER_ERR 18
`define MCH_SS_DATA_PARITY 17
`define MCH_SS_ADDR_PARITY 16
`define MCH_SS_COPY_HI 15

// ==========================================================
// Vector
`define MCH_VEC_OFFSET 32'h00000200
`define MCH_VEC_BASE_HIGH 32'hfff00000
`define MCH_VEC_BASE_LOW 32'h00000000

`endif

// *** rtl/mch_machine_check.v ***
// Purpose: Machine check exception logic of a processor core
// Assumes: Parity, cache and address error inputs are one-cycle pulses
//          on REF_CLK; check pin, transfer error and soft reset are
//          asynchronous active-low pins
// Notes:   Registers sit on a plain strobe port, read data one cycle later
`include "mch_defines.vh"

module mch_machine_check (
   input wire REF_CLK,
   input wire RST_N,
   input wire SOFT_RESET_N,
   input wire MACHINE_CHECK_PIN_N,
   input wire TRANSFER_ERROR_ACK_N,
   input wire ADDR_PARITY_ERR,
   input wire DATA_PARITY_ERR,
   input wire L1_PARITY_ERR,
   input wire L2_PARITY_ERR,
   input wire NONEXIST_ADDR_ERR,
   input wire [31:0] CURRENT_EA,
   input wire [7:0] REG_ADDR,
   input wire [31:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output reg [31:0] REG_RDATA,
   output reg EXCEPTION_TAKEN,
   output reg [31:0] VECTOR_ADDR,
   output reg CHECKSTOP,
   output reg LATCH_FREEZE,
   output reg PARITY_GEN_EN
);

   // ==========================================================
   // Pin synchronisers
   reg pin_s1;
   reg pin_s2;
   reg pin_d;
   reg tea_s1;
   reg tea_s2;
   reg tea_d;
   reg srst_s1;
   reg srst_s2;
   reg srst_d;

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
         pin_d <= 1'b1;
      end else begin
         pin_s1 <= MACHINE_CHECK_PIN_N;
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
      end
   end

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tea_s1 <= 1'b1;
         tea_s2 <= 1'b1;
         tea_d <= 1'b1;
      end else begin
         tea_s1 <= TRANSFER_ERROR_ACK_N;
         tea_s2 <= tea_s1;
         tea_d <= tea_s2;
      end
   end

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         srst_s1 <= 1'b1;
         srst_s2 <= 1'b1;
         srst_d <= 1'b1;
      end else begin
         srst_s1 <= SOFT_RESET_N;
         srst_s2 <= srst_s1;
         srst_d <= srst_s2;
      end
   end

   // Falling edges of the active-low pins
   wire pin_fall = pin_d & ~pin_s2;
   wire tea_fall = tea_d & ~tea_s2;
   wire soft_reset = srst_d & ~srst_s2;

   // ==========================================================
   // Registers
   reg [31:0] config_reg;
   reg [31:0] saved_state;
   reg [31:0] return_addr;
   reg [31:0] machine_state;

   wire check_enable = machine_state[`MCH_MS_CHECK_ENABLE];
   wire prefix = machine_state[`MCH_MS_EXCEPTION_PREFIX];

   // ==========================================================
   // Source qualification
   wire src_pin = pin_fall & config_reg[`MCH_CFG_CHECK_PIN_ENABLE];
   wire src_addr = ADDR_PARITY_ERR & config_reg[`MCH_CFG_ADDR_PARITY_CHECK];
   wire src_data = DATA_PARITY_ERR & config_reg[`MCH_CFG_DATA_PARITY_CHECK];
   // Taken whenever it arrives, not tied to any instruction
   wire src_tea = tea_fall;
   wire src_l1 = L1_PARITY_ERR;
   wire src_l2 = L2_PARITY_ERR;
   // Deferred errors arrive whenever the write-back reports them
   wire src_nonexist = NONEXIST_ADDR_ERR;

   // Any enabled source raises the condition, except while CHECKSTOP is set
   wire check_event = ~CHECKSTOP &
      (src_pin | src_addr | src_data | src_tea | src_l1 | src_l2 | src_nonexist);

   wire take_exc = check_event & check_enable;
   wire go_stop = check_event & ~check_enable;

   // ==========================================================
   // Vector address
   function [31:0] vector_of;
      input p;
      begin
         if (p) begin
            vector_of = `MCH_VEC_BASE_HIGH | `MCH_VEC_OFFSET;
         end else begin
            vector_of = `MCH_VEC_BASE_LOW | `MCH_VEC_OFFSET;
         end
      end
   endfunction

   // ==========================================================
   // Next register values
   reg [31:0] next_saved_state;
   reg [31:0] next_machine_state;

   always @* begin
      next_saved_state = 32'h00000000;
      next_saved_state[`MCH_SS_COPY_HI:0] = machine_state[`MCH_SS_COPY_HI:0];
      next_saved_state[`MCH_SS_L2_PARITY] = src_l2;
      next_saved_state[`MCH_SS_CHECK_PIN] = src_pin;
      next_saved_state[`MCH_SS_TRANSFER_ERR] = src_tea;
      next_saved_state[`MCH_SS_DATA_PARITY] = src_data;
      next_saved_state[`MCH_SS_ADDR_PARITY] = src_addr;
   end

   always @* begin
      next_machine_state = 32'h00000000;
      next_machine_state[`MCH_MS_INT_LITTLE_ENDIAN] = machine_state[`MCH_MS_INT_LITTLE_ENDIAN];
      next_machine_state[`MCH_MS_EXCEPTION_PREFIX] = prefix;
      next_machine_state[`MCH_MS_LITTLE_ENDIAN] = machine_state[`MCH_MS_INT_LITTLE_ENDIAN];
   end

   // ==========================================================
   // Register decode
   function reg_hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         reg_hit = (a == ofs);
      end
   endfunction

   wire wr_ok = REG_WR & ~CHECKSTOP;
   wire wr_config = wr_ok & reg_hit(REG_ADDR, `MCH_OFS_CONFIG);
   wire wr_saved = wr_ok & reg_hit(REG_ADDR, `MCH_OFS_SAVED_STATE);
   wire wr_return = wr_ok & reg_hit(REG_ADDR, `MCH_OFS_RETURN_ADDR);
   wire wr_state = wr_ok & reg_hit(REG_ADDR, `MCH_OFS_MACHINE_STATE);

   // ==========================================================
   // Configuration register
   // Only hard reset reaches this register; soft reset leaves it
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         config_reg <= `MCH_RST_CONFIG;
      end else if (wr_config) begin
         config_reg <= REG_WDATA;
      end
   end

   // ==========================================================
   // Exception state registers
   // An exception outranks a software write in the same cycle
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         saved_state <= `MCH_RST_SAVED_STATE;
      end else if (take_exc) begin
         saved_state <= next_saved_state;
      end else if (wr_saved) begin
         saved_state <= REG_WDATA;
      end
   end

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         return_addr <= `MCH_RST_RETURN_ADDR;
      end else if (take_exc) begin
         return_addr <= CURRENT_EA;
      end else if (wr_return) begin
         return_addr <= REG_WDATA;
      end
   end

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         machine_state <= `MCH_RST_MACHINE_STATE;
      end else if (take_exc) begin
         machine_state <= next_machine_state;
      end else if (wr_state) begin
         machine_state <= REG_WDATA;
      end
   end

   // ==========================================================
   // Exception outputs
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         EXCEPTION_TAKEN <= 1'b0;
      end else begin
         EXCEPTION_TAKEN <= take_exc;
      end
   end

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         VECTOR_ADDR <= `MCH_VEC_BASE_LOW | `MCH_VEC_OFFSET;
      end else if (take_exc) begin
         VECTOR_ADDR <= vector_of(prefix);
      end
   end

   // ==========================================================
   // Checkstop and freeze
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CHECKSTOP <= 1'b0;
         LATCH_FREEZE <= 1'b0;
      end else if (go_stop) begin
         // A new check outranks a soft reset edge in the same cycle
         CHECKSTOP <= 1'b1;
         LATCH_FREEZE <= 1'b1;
      end else if (soft_reset) begin
         CHECKSTOP <= 1'b0;
         LATCH_FREEZE <= 1'b0;
      end else begin
         LATCH_FREEZE <= CHECKSTOP;
      end
   end

   // ==========================================================
   // Parity generation control
   // Software is expected to clear both check bits along with this one
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PARITY_GEN_EN <= 1'b0;
      end else begin
         PARITY_GEN_EN <= config_reg[`MCH_CFG_BUS_PARITY_GENERATE];
      end
   end

   // ==========================================================
   // Read port
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= 32'h00000000;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `MCH_OFS_CONFIG: begin
               REG_RDATA <= config_reg;
            end
            `MCH_OFS_SAVED_STATE: begin
               REG_RDATA <= saved_state;
            end
            `MCH_OFS_RETURN_ADDR: begin
               REG_RDATA <= return_addr;
            end
            `MCH_OFS_MACHINE_STATE: begin
               REG_RDATA <= machine_state;
            end
            default: begin
               REG_RDATA <= 32'h00000000;
            end
         endcase
      end else begin
         REG_RDATA <= 32'h00000000;
      end
   end

endmodule

// *** sim/mch_machine_check_chk.sv ***
// Purpose: Port checker for the machine check handler
// Assumes: One clock domain, RST_N async active low
// Notes: Bound to every instance of the top module
module mch_chk (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic SOFT_RESET_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic EXCEPTION_TAKEN,
   input wire logic [31:0] VECTOR_ADDR,
   input wire logic CHECKSTOP,
   input wire logic LATCH_FREEZE,
   input wire logic PARITY_GEN_EN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // ==========
   // Assertions
   exc_pulse_a: assert property (EXCEPTION_TAKEN |=> !EXCEPTION_TAKEN)
      else $error("exception pulse too long");
   vec_base_a: assert property (EXCEPTION_TAKEN |-> VECTOR_ADDR inside {32'h200, 32'hfff00200})
      else $error("bad vector");
   vec_hold_a: assert property (!EXCEPTION_TAKEN |-> $stable(VECTOR_ADDR))
      else $error("vector moved without exception");
   freeze_stop_a: assert property (CHECKSTOP == LATCH_FREEZE)
      else $error("freeze differs from checkstop");
   stop_no_exc_a: assert property (CHECKSTOP |-> !EXCEPTION_TAKEN)
      else $error("exception in checkstop");
   stop_hold_a: assert property (CHECKSTOP && $past(SOFT_RESET_N, 2) |=> CHECKSTOP)
      else $error("checkstop left without reset");
   par_gen_a: assert property (REG_WR && REG_ADDR == 8'h00 && !CHECKSTOP
      |=> ##1 PARITY_GEN_EN == $past(REG_WDATA[30], 2))
      else $error("parity generate not following config");
   flag_store_a: assert property (REG_RD && $past(REG_WR) && !$past(CHECKSTOP) && REG_ADDR == 8'h00
      && $past(REG_ADDR) == 8'h00 |=> REG_RDATA[16] == $past(REG_WDATA[16], 2))
      else $error("software flag not stored");
   cover property (EXCEPTION_TAKEN && VECTOR_ADDR == 32'hfff00200);
   cover property ($rose(CHECKSTOP));
   cover property ($fell(CHECKSTOP));
endmodule

bind mch_machine_check mch_chk chk (.REF_CLK, .RST_N, .SOFT_RESET_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
   .REG_RDATA, .EXCEPTION_TAKEN, .VECTOR_ADDR, .CHECKSTOP, .LATCH_FREEZE, .PARITY_GEN_EN);

// *** sim/mch_bus_model.sv ***
// Purpose: Bus controller model driving the error lines
// Assumes: Both error lines are pulled up when released
// Notes: A request holds its line low four cycles
module mch_bus_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tea_req,
   input wire logic pin_req,
   output logic tea_n,
   output logic pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] tea_cnt;
   logic [2:0] pin_cnt;
   // ==========
   // Error lines
   assign tea_n = tea_cnt == 3'h0;
   assign pin_n = pin_cnt == 3'h0;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tea_cnt <= 3'h0;
         pin_cnt <= 3'h0;
      end else begin
         tea_cnt <= tea_req ? 3'h4 : tea_cnt - 3'(tea_cnt != 3'h0);
         pin_cnt <= pin_req ? 3'h4 : pin_cnt - 3'(pin_cnt != 3'h0);
      end
   end
endmodule

// *** sim/mch_machine_check_tb.sv ***
// Purpose: Self-checking bench for the machine check handler
// Assumes: Inputs change right after rising edges
// Notes: Error lines come from the bus controller model
module mch_machine_check_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic REF_CLK = 0, RST_N = 0, SOFT_RESET_N = 1, REG_WR = 0, REG_RD = 0, tea_req = 0, pin_req = 0;
   logic [4:0] err = 5'h0;
   logic [7:0] REG_ADDR = 8'h0;
   logic [31:0] REG_WDATA = 32'h0, CURRENT_EA = 32'h0;
   wire TEA_N, PIN_N, EXCEPTION_TAKEN, CHECKSTOP, LATCH_FREEZE, PARITY_GEN_EN;
   wire [31:0] REG_RDATA, VECTOR_ADDR;
   int failures = 0, compares = 0, cycles = 0;
   logic seen_exc, seen_stop;
   always #2.5 REF_CLK = ~REF_CLK;
   mch_bus_model bus (.clk(REF_CLK), .rst_n(RST_N), .tea_req, .pin_req, .tea_n(TEA_N), .pin_n(PIN_N));
   mch_machine_check dut (.REF_CLK, .RST_N, .SOFT_RESET_N, .MACHINE_CHECK_PIN_N(PIN_N),
      .TRANSFER_ERROR_ACK_N(TEA_N), .ADDR_PARITY_ERR(err[4]), .DATA_PARITY_ERR(err[3]),
      .L1_PARITY_ERR(err[2]), .L2_PARITY_ERR(err[1]), .NONEXIST_ADDR_ERR(err[0]), .CURRENT_EA,
      .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .EXCEPTION_TAKEN, .VECTOR_ADDR,
      .CHECKSTOP, .LATCH_FREEZE, .PARITY_GEN_EN);
   // ==========
   // Shared tasks
   task finish_test;
      if (failures == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge REF_CLK);
      REG_WR <= 1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge REF_CLK);
      REG_WR <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      REG_RD <= 1;
      REG_ADDR <= a;
      @(posedge REF_CLK);
      REG_RD <= 0;
      @(negedge REF_CLK);
      chk(REG_RDATA, exp);
      @(posedge REF_CLK);
   endtask
   task fire(input logic [4:0] e, input logic t, input logic p);
      @(posedge REF_CLK);
      err <= e;
      tea_req <= t;
      pin_req <= p;
      @(posedge REF_CLK);
      err <= 5'h0;
      tea_req <= 0;
      pin_req <= 0;
      seen_exc = 0;
      seen_stop = 0;
      repeat (8) begin
         @(negedge REF_CLK);
         seen_exc |= EXCEPTION_TAKEN;
         seen_stop |= CHECKSTOP;
      end
      @(posedge REF_CLK);
   endtask
   task took(input logic [31:0] vec, input logic [31:0] ss);
      chk(32'({seen_exc, seen_stop}), 32'h2);
      chk(VECTOR_ADDR, vec);
      rd(8'h04, ss);
   endtask
   // ==========
   // Scenarios
   task multi_source;
      wr(8'h00, 32'hf0010000);
      rd(8'h00, 32'hf0010000);
      wr(8'h0c, 32'h00011043);
      CURRENT_EA <= 32'h00abc120;
      fire(5'b11010, 0, 0);
      took(32'hfff00200, 32'h00131043);
      rd(8'h08, 32'h00abc120);
      rd(8'h0c, 32'h00010041);
      chk(32'(PARITY_GEN_EN), 32'h1);
   endtask
   task checkstop_soft;
      fire(5'b00100, 0, 0);
      chk(32'({seen_exc, seen_stop, LATCH_FREEZE}), 32'h3);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'hf0010000);
      SOFT_RESET_N <= 0;
      repeat (5) @(posedge REF_CLK);
      SOFT_RESET_N <= 1;
      repeat (4) @(posedge REF_CLK);
      rd(8'h00, 32'hf0010000);
      chk(32'(CHECKSTOP), 32'h0);
   endtask
   task gated;
      wr(8'h00, 32'h20000000);
      wr(8'h0c, 32'h00001000);
      fire(5'b01000, 0, 1);
      chk(32'({seen_exc, seen_stop, PARITY_GEN_EN}), 32'h0);
      wr(8'h00, 32'h80000000);
      fire(5'b10000, 0, 0);
      chk(32'({seen_exc, seen_stop}), 32'h0);
      fire(5'h0, 0, 1);
      took(32'h200, 32'h00081000);
      wr(8'h0c, 32'h00001000);
      fire(5'h0, 1, 0);
      took(32'h200, 32'h00041000);
      wr(8'h0c, 32'h00001000);
      fire(5'h01, 0, 0);
      took(32'h200, 32'h00001000);
   endtask
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         finish_test;
      end
   end
   initial begin
      repeat (3) @(posedge REF_CLK);
      RST_N <= 1;
      @(posedge REF_CLK);
      for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
      multi_source;
      checkstop_soft;
      gated;
      wr(8'h00, 32'h00010000);
      rd(8'h00, 32'h00010000);
      RST_N <= 0;
      repeat (3) @(posedge REF_CLK);
      RST_N <= 1;
      @(posedge REF_CLK);
      rd(8'h00, 32'h0);
      finish_test;
   end
endmodule
